// *** rtl/dac_core.sv ***
// converter side: rate decode, reset sequencing, init period and power-down
// How it works
// [RULE_01] one of three modes, register or pins
// [RULE_02] code 00 single, 01 dual, 10 quad
// [RULE_03] single: up to 54kHz, 128x oversampling
// [RULE_04] dual: up to 108kHz, 64x oversampling
// [RULE_05] quad: up to 216kHz, 32x oversampling
// [RULE_06] host clock is 128..768 times fs
// [RULE_07] host matches clock multiple to mode
// [RULE_08] after reset, detect clock, then 1024-cycle init
// [RULE_09] accept audio only after init completes
// [RULE_10] software mode: registers default during init
// [RULE_11] outputs muted through reset and init
// [RULE_12] reset pin low at least 40ns, clock running
// [RULE_13] reset pin rising edge starts init
// [RULE_14] software reset bit starts identical init
// [RULE_15] daisy chain only up to 108kHz
// [RULE_16] pin low 65536 cycles enters power-down
// [RULE_17] software reset bit clears after init
// [RULE_18] clock judged active after few edges
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dac_core #(
  parameter int INIT_LEN = dac_ctrl_pkg::INIT_CYCLES,
  parameter int PDN_LEN  = dac_ctrl_pkg::PDN_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // link to host
  dac_link_if.device link,
  // status to user side
  output logic [1:0] rate_mode,
  output logic [7:0] osr,
  output logic       mute,
  output logic       audio_ready,
  output logic       powered_down,
  output logic       rate_illegal,
  output logic [7:0] ctrl_reg
);

  typedef enum logic [2:0] {ST_RESET, ST_WAIT_CLK, ST_INIT, ST_RUN, ST_PDN} seq_state_t;

  seq_state_t  state;
  logic        clk_q1;
  logic        clk_q2;
  logic        clk_q3;
  logic [2:0]  edge_cnt;
  logic [15:0] init_cnt;
  logic [16:0] low_cnt;
  logic        pin_q;
  logic        pin_rise;
  logic        sw_rst_req;
  logic        clk_edge;
  logic [1:0]  next_mode;

  // sys_clk_in is sampled as a plain level; two stages, then edge compare
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clk_q1 <= 1'b0;
      clk_q2 <= 1'b0;
      clk_q3 <= 1'b0;
      pin_q  <= 1'b1;
    end else begin
      clk_q1 <= link.sys_clk_in;
      clk_q2 <= clk_q1;
      clk_q3 <= clk_q2;
      pin_q  <= link.rst_pin_n;
    end
  end

  assign clk_edge   = clk_q2 & ~clk_q3;
  assign pin_rise   = link.rst_pin_n & ~pin_q;                           // see [RULE_13]
  assign sw_rst_req = link.sw_mode & link.spi_we
                      & (link.spi_addr == dac_ctrl_pkg::CTRL_REG_ADDR)
                      & link.spi_wdata[dac_ctrl_pkg::RST_BIT];            // see [RULE_14]

  // low-time counter for the reset pin; saturates at the power-down length
  always_ff @(posedge clock) begin
    if (sys_rst || link.rst_pin_n) begin
      low_cnt <= '0;
    end else if (low_cnt < 17'(PDN_LEN)) begin
      low_cnt <= low_cnt + 17'h00001;                                    // see [RULE_16]
    end
  end

  // reset sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= ST_RESET;
      edge_cnt <= '0;
      init_cnt <= '0;
    end else begin
      unique case (state)
        ST_RESET: begin
          edge_cnt <= '0;
          if (link.rst_pin_n) begin
            state <= ST_WAIT_CLK;                                        // see [RULE_08]
          end
        end
        ST_WAIT_CLK: begin
          if (!link.rst_pin_n) begin
            state <= ST_RESET;
          end else if (clk_edge) begin
            if (edge_cnt == 3'(dac_ctrl_pkg::CLK_DET_EDGES - 1)) begin
              state    <= ST_INIT;                                       // see [RULE_18]
              init_cnt <= '0;
            end
            edge_cnt <= edge_cnt + 3'h1;
          end
        end
        ST_INIT: begin
          if (!link.rst_pin_n) begin
            state <= ST_RESET;
          end else if (sw_rst_req) begin
            init_cnt <= '0;                                              // see [RULE_14]
          end else if (clk_edge) begin
            // init counts sys_clk_in periods, not core clocks
            if (init_cnt == 16'(INIT_LEN - 1)) begin
              state <= ST_RUN;                                           // see [RULE_08]
            end
            init_cnt <= init_cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          if (!link.rst_pin_n) begin
            state <= ST_RESET;
          end else if (sw_rst_req) begin
            state    <= ST_INIT;                                         // see [RULE_14]
            init_cnt <= '0;
          end
        end
        ST_PDN: begin
          // rising pin leaves power-down through a fresh init
          if (pin_rise) begin
            state    <= ST_INIT;                                         // see [RULE_13]
            init_cnt <= '0;
          end
        end
      endcase
      if (!link.rst_pin_n && low_cnt >= 17'(PDN_LEN - 1)) begin
        state <= ST_PDN;                                                 // see [RULE_16]
      end
    end
  end

  // control register; defaults during reset and init, reset bit self-clears
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_reg <= dac_ctrl_pkg::CTRL_RESET;
    end else if (link.sw_mode && link.spi_we
                 && link.spi_addr == dac_ctrl_pkg::CTRL_REG_ADDR) begin
      ctrl_reg <= link.spi_wdata;
    end else if (state != ST_RUN) begin
      ctrl_reg <= dac_ctrl_pkg::CTRL_RESET;                              // see [RULE_10] [RULE_17]
    end
  end

  // mode source: register bits in software mode, pins otherwise
  always_comb begin
    if (link.sw_mode) begin
      next_mode = ctrl_reg[dac_ctrl_pkg::RATE_LSB +: 2];                 // see [RULE_01]
    end else begin
      next_mode = {link.rate_sel_pin_hi, link.rate_sel_pin_lo};         // see [RULE_01]
    end
  end

  // rate decode; unused code falls back to single rate and raises a flag
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rate_mode    <= dac_ctrl_pkg::RATE_SINGLE;
      osr          <= dac_ctrl_pkg::OSR_SINGLE;
      rate_illegal <= 1'b0;
    end else begin
      rate_illegal <= (next_mode == dac_ctrl_pkg::RATE_UNUSED);          // see [RULE_02]
      unique case (next_mode)
        dac_ctrl_pkg::RATE_DUAL: begin
          rate_mode <= next_mode;
          osr       <= dac_ctrl_pkg::OSR_DUAL;                           // see [RULE_04]
        end
        dac_ctrl_pkg::RATE_QUAD: begin
          rate_mode <= next_mode;
          osr       <= dac_ctrl_pkg::OSR_QUAD;                           // see [RULE_05]
        end
        default: begin
          rate_mode <= dac_ctrl_pkg::RATE_SINGLE;
          osr       <= dac_ctrl_pkg::OSR_SINGLE;                         // see [RULE_03]
        end
      endcase
    end
  end

  // output status flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mute         <= 1'b1;
      audio_ready  <= 1'b0;
      powered_down <= 1'b0;
    end else begin
      mute         <= (state != ST_RUN);                                 // see [RULE_11]
      audio_ready  <= (state == ST_RUN);                                 // see [RULE_09]
      powered_down <= (state == ST_PDN);                                 // see [RULE_16]
    end
  end

endmodule : dac_core

// *** rtl/dac_ctrl_pkg.sv ***
// shared constants for the converter reset, clock and rate control core
package dac_ctrl_pkg;

  // rate mode codes
  typedef enum logic [1:0] {
    RATE_SINGLE = 2'h0,
    RATE_DUAL   = 2'h1,
    RATE_QUAD   = 2'h2,
    RATE_UNUSED = 2'h3
  } rate_mode_t;

  // oversampling ratios per mode
  localparam logic [7:0] OSR_SINGLE = 8'h80;
  localparam logic [7:0] OSR_DUAL   = 8'h40;
  localparam logic [7:0] OSR_QUAD   = 8'h20;

  // sample rate ceilings in kHz
  localparam int SINGLE_MAX_KHZ = 54;
  localparam int DUAL_MAX_KHZ   = 108;
  localparam int QUAD_MAX_KHZ   = 216;

  // control register 6 layout (rate field, reset bit)
  localparam logic [3:0] CTRL_REG_ADDR = 4'h6;
  localparam int         RATE_LSB      = 0;
  localparam int         RST_BIT       = 7;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // software port map of the host controller
  localparam logic [3:0] HOST_CMD_ADDR  = 4'h0;
  localparam logic [3:0] HOST_STAT_ADDR = 4'h1;
  localparam int         CMD_RESET_BIT  = 0;
  localparam int         CMD_PDN_BIT    = 1;
  localparam int         CMD_SW_BIT     = 2;
  localparam int         CMD_RATE_LSB   = 4;
  localparam int         CMD_MULT_LSB   = 8;

  // timing
  localparam int INIT_CYCLES    = 1024;
  localparam int PDN_CYCLES     = 65536;
  localparam int CLK_DET_EDGES  = 4;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int RST_MIN_NS     = 40;
  localparam int RST_MIN_CYCLES = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // clock multiple indices: 128,192,256,384,512,768
  localparam logic [2:0] MULT_128 = 3'h0;
  localparam logic [2:0] MULT_192 = 3'h1;
  localparam logic [2:0] MULT_256 = 3'h2;
  localparam logic [2:0] MULT_384 = 3'h3;
  localparam logic [2:0] MULT_512 = 3'h4;
  localparam logic [2:0] MULT_768 = 3'h5;

endpackage : dac_ctrl_pkg

// *** rtl/dac_link_if.sv ***
// interface joining the host controller and the converter control core
`timescale 1ns/1ps
interface dac_link_if;
  logic       sys_clk_in;
  logic       rst_pin_n;
  logic       rate_sel_pin_lo;
  logic       rate_sel_pin_hi;
  logic       sw_mode;
  logic       spi_we;
  logic [3:0] spi_addr;
  logic [7:0] spi_wdata;

  modport device (input sys_clk_in, rst_pin_n, rate_sel_pin_lo, rate_sel_pin_hi,
                  sw_mode, spi_we, spi_addr, spi_wdata);
  modport host   (output sys_clk_in, rst_pin_n, rate_sel_pin_lo, rate_sel_pin_hi,
                  sw_mode, spi_we, spi_addr, spi_wdata);
endinterface : dac_link_if

// *** rtl/dac_host.sv ***
// host side: makes the converter clock, drives reset pin, rate pins and register writes
`timescale 1ns/1ps
module dac_host #(
  parameter int CLK_DIV  = 2,
  parameter int PDN_HOLD = dac_ctrl_pkg::PDN_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // software port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // link to device
  dac_link_if.host link
);

  logic [15:0] cmd;
  logic [7:0]  div_cnt;
  logic [16:0] hold_cnt;
  logic        busy;
  logic        clk_out;
  logic        mult_ok;
  logic        chain_ok;
  logic [1:0]  mode;
  logic [2:0]  mult;

  assign mode = cmd[dac_ctrl_pkg::CMD_RATE_LSB +: 2];
  assign mult = cmd[dac_ctrl_pkg::CMD_MULT_LSB +: 3];
  // two chained converters share one line only up to dual rate (108kHz)
  assign chain_ok = (mode == dac_ctrl_pkg::RATE_SINGLE)
                    || (mode == dac_ctrl_pkg::RATE_DUAL);                 // see [RULE_15]

  // clock multiple allowed for the mode
  always_comb begin
    unique case (mode)
      dac_ctrl_pkg::RATE_SINGLE: mult_ok = mult inside {dac_ctrl_pkg::MULT_256,
        dac_ctrl_pkg::MULT_384, dac_ctrl_pkg::MULT_512, dac_ctrl_pkg::MULT_768}; // see [RULE_07]
      dac_ctrl_pkg::RATE_DUAL:   mult_ok = mult inside {dac_ctrl_pkg::MULT_256,
        dac_ctrl_pkg::MULT_384};                                          // see [RULE_07]
      dac_ctrl_pkg::RATE_QUAD:   mult_ok = mult inside {dac_ctrl_pkg::MULT_128,
        dac_ctrl_pkg::MULT_192};                                          // see [RULE_07]
      default:                   mult_ok = 1'b0;
    endcase
  end

  // command register; reset bit is a one-shot, cleared by hardware
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd <= 16'h0000;
    end else if (wr && addr == dac_ctrl_pkg::HOST_CMD_ADDR) begin
      cmd <= wdata;
    end else if (busy && hold_cnt == '0) begin
      cmd[dac_ctrl_pkg::CMD_RESET_BIT] <= 1'b0;
    end
  end

  // divided clock; held low while the clock multiple is bad for the mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_cnt <= '0;
      clk_out <= 1'b0;
    end else if (div_cnt == 8'(CLK_DIV - 1)) begin
      div_cnt <= '0;
      clk_out <= ~clk_out & mult_ok;                                     // see [RULE_06]
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // reset pin pulse: long enough, and only with the clock running
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy     <= 1'b0;
      hold_cnt <= '0;
    end else if (!busy && cmd[dac_ctrl_pkg::CMD_RESET_BIT] && mult_ok) begin
      busy     <= 1'b1;
      hold_cnt <= cmd[dac_ctrl_pkg::CMD_PDN_BIT] ? 17'(PDN_HOLD)
                  : 17'(dac_ctrl_pkg::RST_MIN_CYCLES * 2 * CLK_DIV);     // see [RULE_12]
    end else if (busy) begin
      if (hold_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        hold_cnt <= hold_cnt - 17'h00001;
      end
    end
  end

  // pin outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link.sys_clk_in      <= 1'b0;
      link.rst_pin_n       <= 1'b0;
      link.rate_sel_pin_lo <= 1'b0;
      link.rate_sel_pin_hi <= 1'b0;
      link.sw_mode         <= 1'b0;
      link.spi_we          <= 1'b0;
      link.spi_addr        <= 4'h0;
      link.spi_wdata       <= 8'h00;
    end else begin
      link.sys_clk_in      <= clk_out;
      link.rst_pin_n       <= ~busy;
      link.rate_sel_pin_lo <= mode[0];
      link.rate_sel_pin_hi <= mode[1];
      // new mode travels with the mirrored write, else that write would be lost
      link.sw_mode         <= (wr && addr == dac_ctrl_pkg::HOST_CMD_ADDR)
                              ? wdata[dac_ctrl_pkg::CMD_SW_BIT]
                              : cmd[dac_ctrl_pkg::CMD_SW_BIT];
      // mirror command writes into the device register in software mode
      link.spi_we          <= wr && addr == dac_ctrl_pkg::HOST_CMD_ADDR
                              && wdata[dac_ctrl_pkg::CMD_SW_BIT];
      link.spi_addr        <= dac_ctrl_pkg::CTRL_REG_ADDR;
      link.spi_wdata       <= {wdata[15], 5'h00, wdata[dac_ctrl_pkg::CMD_RATE_LSB +: 2]};
    end
  end

  // read port, one cycle latency; status bit2 says whether chaining is allowed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else if (rd && addr == dac_ctrl_pkg::HOST_CMD_ADDR) begin
      rdata <= cmd;
    end else if (rd && addr == dac_ctrl_pkg::HOST_STAT_ADDR) begin
      rdata <= {13'h0000, chain_ok, mult_ok, busy};                      // see [RULE_15]
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule : dac_host

// *** testbench/dac_link_sva.sv ***
// concurrent checks on the link and the converter status outputs
`timescale 1ns/1ps
module dac_link_sva #(
  parameter int INIT_LEN = dac_ctrl_pkg::INIT_CYCLES,
  parameter int PDN_LEN  = dac_ctrl_pkg::PDN_CYCLES
) (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // link signals
  input wire logic       sys_clk_in,
  input wire logic       rst_pin_n,
  input wire logic       rate_sel_pin_lo,
  input wire logic       rate_sel_pin_hi,
  input wire logic       sw_mode,
  input wire logic       spi_we,
  input wire logic [3:0] spi_addr,
  input wire logic [7:0] spi_wdata,
  // converter status
  input wire logic [1:0] rate_mode,
  input wire logic [7:0] osr,
  input wire logic       mute,
  input wire logic       audio_ready,
  input wire logic       powered_down,
  input wire logic [7:0] ctrl_reg
);
  logic        sck_q;
  logic        sw_hit;
  logic [1:0]  pins;
  logic [7:0]  exp_osr;
  int unsigned edges;
  int unsigned low_len;

  // software reset request seen on the register write path
  assign sw_hit = spi_we && spi_addr == dac_ctrl_pkg::CTRL_REG_ADDR
                  && spi_wdata[dac_ctrl_pkg::RST_BIT];
  assign pins   = {rate_sel_pin_hi, rate_sel_pin_lo};

  // expected ratio for the decoded mode
  always_comb begin
    case (rate_mode)
      dac_ctrl_pkg::RATE_DUAL: exp_osr = dac_ctrl_pkg::OSR_DUAL;
      dac_ctrl_pkg::RATE_QUAD: exp_osr = dac_ctrl_pkg::OSR_QUAD;
      default:                 exp_osr = dac_ctrl_pkg::OSR_SINGLE;
    endcase
  end

  // converter clock edges since the last reset request
  always_ff @(posedge clock) begin
    sck_q <= sys_clk_in;
    if (sys_rst || !rst_pin_n || sw_hit) edges <= 0;
    else if (sys_clk_in && !sck_q) edges <= edges + 1;
  end

  // length of the current low pulse on the pin, saturating so it never wraps
  always_ff @(posedge clock) begin
    if (sys_rst || rst_pin_n) low_len <= 0;
    else if (low_len < PDN_LEN + 8) low_len <= low_len + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_sw_req;
    sw_hit && sw_mode && audio_ready;
  endsequence
  sequence s_reinit;
    ##[1:4] (mute && !audio_ready);
  endsequence

  a_mute_on_pin: assert property ($fell(rst_pin_n) |-> ##[1:4] mute)
    else $error("mute did not follow the reset pin");
  a_ready_unmuted: assert property (audio_ready |-> !mute)
    else $error("audio accepted while muted");
  a_pdn_quiet: assert property (powered_down |-> mute && !audio_ready)
    else $error("power-down without mute");
  a_pdn_entry: assert property (low_len >= PDN_LEN + 4 |-> powered_down)
    else $error("long reset pulse did not power down");
  a_init_length: assert property ($rose(audio_ready) |->
    edges >= INIT_LEN - 1 && edges <= INIT_LEN + 7)
    else $error("init period length wrong");
  a_osr_match: assert property ($stable(rate_mode) |-> osr == exp_osr)
    else $error("oversampling ratio does not match mode");
  a_pin_rate: assert property ($rose(audio_ready) && !sw_mode |->
    rate_mode == (&pins ? 2'h0 : pins))
    else $error("pin rate decode wrong");
  a_sw_reset: assert property (s_sw_req |-> s_reinit)
    else $error("software reset did not restart init");
  a_ctrl_cleared: assert property (mute && $past(mute) && !spi_we && !$past(spi_we)
    |-> ctrl_reg == dac_ctrl_pkg::CTRL_RESET)
    else $error("control register not default while muted");
  a_pin_width: assert property ($rose(rst_pin_n) |-> $past(rst_pin_n, 2) == 1'b0)
    else $error("reset pin low pulse too short");
endmodule : dac_link_sva

// *** testbench/dac_reset_clock_rate_control_tb.sv ***
// bench for the host and converter control pair joined across the link
`timescale 1ns/1ps
module dac_reset_clock_rate_control_tb;
  localparam int INIT = 16;
  localparam int PDN  = 64;
  logic        clock        = 1'b0;
  logic        sys_rst      = 1'b1;
  logic [3:0]  addr         = 4'h0;
  logic [15:0] wdata        = 16'h0000;
  logic        wr           = 1'b0;
  logic        rd           = 1'b0;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [1:0]  rate_mode;
  logic [7:0]  osr;
  logic [7:0]  ctrl_reg;
  logic        mute;
  logic        audio_ready;
  logic        powered_down;
  logic        rate_illegal;
  int          failures     = 0;
  int          num_checks   = 0;
  // per rate code: multiple, decoded mode, ratio
  logic [2:0]  mult_t [4]   = '{3'h2, 3'h2, 3'h0, 3'h2};
  logic [1:0]  rate_t [4]   = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic [7:0]  osr_t  [4]   = '{8'h80, 8'h40, 8'h20, 8'h80};

  dac_link_if link ();
  // host holds the pin low longer than the core needs, so power-down is reached
  dac_host #(.PDN_HOLD(PDN + 16)) i_dac_host (.clock (clock), .sys_rst (sys_rst),
    .addr (addr), .wdata (wdata), .wr (wr), .rd (rd), .rdata (rdata), .link (link.host));
  dac_core #(.INIT_LEN(INIT), .PDN_LEN(PDN)) i_dac_core (.clock (clock),
    .sys_rst (sys_rst), .link (link.device), .rate_mode (rate_mode), .osr (osr),
    .mute (mute), .audio_ready (audio_ready), .powered_down (powered_down),
    .rate_illegal (rate_illegal), .ctrl_reg (ctrl_reg));
  dac_link_sva #(.INIT_LEN(INIT), .PDN_LEN(PDN)) i_dac_link_sva (.clock (clock),
    .sys_rst (sys_rst), .sys_clk_in (link.sys_clk_in), .rst_pin_n (link.rst_pin_n),
    .rate_sel_pin_lo (link.rate_sel_pin_lo), .rate_sel_pin_hi (link.rate_sel_pin_hi),
    .sw_mode (link.sw_mode), .spi_we (link.spi_we), .spi_addr (link.spi_addr),
    .spi_wdata (link.spi_wdata), .rate_mode (rate_mode), .osr (osr), .mute (mute),
    .audio_ready (audio_ready), .powered_down (powered_down), .ctrl_reg (ctrl_reg));

  always #12.5 clock = ~clock;

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  // sel 0 ready, 1 power-down, 2 mute; a bound that runs out ends the run
  task automatic wait_on(input int sel);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      if ((sel == 0 ? audio_ready : sel == 1 ? powered_down : mute) === 1'b1) return;
    end
    failures++;
    give_verdict();
  endtask : wait_on

  function automatic logic [15:0] cmd(input logic rs, input logic pd, input logic sw,
                                      input logic [1:0] rt, input logic [2:0] m,
                                      input logic dv);
    return {dv, 4'h0, m, 2'h0, rt, 1'b0, sw, pd, rs};
  endfunction : cmd

  task automatic do_reset(input logic [15:0] c);
    wr_reg(dac_ctrl_pkg::HOST_CMD_ADDR, c);
    wait_on(2);
    chk("ready_in_init", 16'h0000, 16'(audio_ready));
    wait_on(0);
  endtask : do_reset

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    // every pin rate code; the unused code has no legal multiple, so no reset pulse
    for (int k = 0; k < 4; k++) begin
      if (k < 3) begin
        do_reset(cmd(1'b1, 1'b0, 1'b0, 2'(k), mult_t[k], 1'b0));
      end else begin
        wr_reg(dac_ctrl_pkg::HOST_CMD_ADDR,
               cmd(1'b1, 1'b0, 1'b0, 2'(k), mult_t[k], 1'b0));
        repeat (6) @(posedge clock);
        #1;
      end
      chk("rate_mode", 16'(rate_t[k]), 16'(rate_mode));
      chk("osr", 16'(osr_t[k]), 16'(osr));
      chk("rate_illegal", 16'(k == 3), 16'(rate_illegal));
      rd_reg(dac_ctrl_pkg::HOST_STAT_ADDR);
      chk("mult_legal", 16'(k != 3), 16'(got[1]));
      chk("chain_ok", 16'(k < 2), 16'(got[2]));
    end
    // quad rate with 768x is refused and the converter keeps running
    wr_reg(dac_ctrl_pkg::HOST_CMD_ADDR, cmd(1'b1, 1'b0, 1'b0, 2'h2, 3'h5, 1'b0));
    repeat (20) @(posedge clock);
    #1 chk("ready_kept", 16'h0001, 16'(audio_ready));
    rd_reg(dac_ctrl_pkg::HOST_STAT_ADDR);
    chk("mult_illegal", 16'h0000, 16'(got[1]));
    rd_reg(4'h5);
    chk("unmapped", 16'h0000, got);
    // software control: registers default after init, then rate from register
    do_reset(cmd(1'b1, 1'b0, 1'b1, 2'h1, 3'h2, 1'b0));
    chk("ctrl_default", 16'h0000, 16'(ctrl_reg));
    chk("sw_rate_default", 16'h0000, 16'(rate_mode));
    wr_reg(dac_ctrl_pkg::HOST_CMD_ADDR, cmd(1'b0, 1'b0, 1'b1, 2'h1, 3'h2, 1'b0));
    repeat (6) @(posedge clock);
    #1 chk("ctrl_written", 16'h0001, 16'(ctrl_reg));
    chk("sw_rate", 16'h0001, 16'(rate_mode));
    chk("sw_osr", 16'h0040, 16'(osr));
    do_reset(cmd(1'b0, 1'b0, 1'b1, 2'h1, 3'h2, 1'b1));
    chk("rst_bit_clear", 16'h0000, 16'(ctrl_reg));
    chk("rate_after_sw", 16'h0000, 16'(rate_mode));
    // long pin hold powers down, release re-initialises; the pulse bit starts the hold
    wr_reg(dac_ctrl_pkg::HOST_CMD_ADDR, cmd(1'b1, 1'b1, 1'b0, 2'h0, 3'h2, 1'b0));
    wait_on(1);
    chk("pdn_mute", 16'h0001, 16'(mute));
    wait_on(0);
    chk("pdn_left", 16'h0000, 16'(powered_down));
    give_verdict();
  end
endmodule : dac_reset_clock_rate_control_tb
